// File: hw/nic_pkg.sv
package nic_pkg;

  // source counts: vectors 0..13, plus reset and trap in front
  localparam int NVEC  = 14;
  localparam int NSRC  = 16;
  localparam int NPINS = 15;
  localparam int NLINE = 4;

  // two-bit software priority encodings
  localparam logic [1:0] LVL0_BITS = 2'h2;
  localparam logic [1:0] LVL1_BITS = 2'h1;
  localparam logic [1:0] LVL2_BITS = 2'h0;
  localparam logic [1:0] LVL3_BITS = 2'h3;
  // level used for reset, trap and top-level sources in arbitration
  localparam logic [2:0] LVL_NMI   = 3'h4;

  // vector addresses
  localparam logic [15:0] RESET_VEC = 16'hFFFE;
  localparam logic [15:0] TRAP_VEC  = 16'hFFFC;
  localparam logic [15:0] VEC0_ADDR = 16'hFFFA;

  // register addresses on the plain port
  localparam logic [7:0] ADDR_EXT_CTL   = 8'h20;
  localparam logic [7:0] ADDR_PEND_LO   = 8'h21;
  localparam logic [7:0] ADDR_PEND_HI   = 8'h22;
  localparam logic [7:0] ADDR_CORE_STAT = 8'h23;
  localparam logic [7:0] ADDR_PRIO0     = 8'h24;
  localparam logic [7:0] ADDR_PRIO1     = 8'h25;
  localparam logic [7:0] ADDR_PRIO2     = 8'h26;
  localparam logic [7:0] ADDR_PRIO3     = 8'h27;
  localparam logic [7:0] ADDR_PIN_SEL_LO = 8'h28;
  localparam logic [7:0] ADDR_PIN_SEL_HI = 8'h29;
  localparam logic [7:0] ADDR_MISC_CTL  = 8'h2A;

  // reset values and fixed bits
  localparam logic [7:0]  PRIO_RESET    = 8'hFF;
  localparam logic [7:0]  PRIO3_RO_MASK = 8'hF0;
  localparam logic [7:0]  EXT_CTL_RESET = 8'h00;
  localparam logic [14:0] PIN_SEL_RESET = 15'h0000;
  localparam logic        TLI_RISE_RESET = 1'b0;
  localparam int          MISC_TLI_RISE = 0;

  // per-vector capability masks (bit n = vector n)
  localparam logic [13:0] HALT_CAP    = 14'h207D;
  localparam logic [13:0] MCC_MASK    = 14'h0002;
  localparam logic [13:0] PERIPH_MASK = 14'h2FC2;
  localparam logic [13:0] EXT_MASK    = 14'h003C;
  localparam int          EXT_VEC0    = 2;

  // sensitivity codes for each external line
  localparam logic [1:0] SENS_LEVEL = 2'h0;
  localparam logic [1:0] SENS_RISE  = 2'h1;
  localparam logic [1:0] SENS_FALL  = 2'h2;
  localparam logic [1:0] SENS_BOTH  = 2'h3;

  // pins belonging to each external line group
  function automatic logic [14:0] nic_line_pins(input int l);
    case (l)
      0:       nic_line_pins = 15'h000F;
      1:       nic_line_pins = 15'h0070;
      2:       nic_line_pins = 15'h0780;
      default: nic_line_pins = 15'h7800;
    endcase
  endfunction : nic_line_pins

  // instruction events reported by the core
  typedef struct packed {
    logic       instr_end;
    logic       irq_enable_instr;
    logic       irq_disable_instr;
    logic       halt_instr;
    logic       wait_for_irq_instr;
    logic       trap_instr;
    logic       irq_return_instr;
    logic       pop_cc;
    logic [1:0] pop_bits;
  } nic_core_ev_t;

  // service request handed to the core
  typedef struct packed {
    logic        take;
    logic        stack;
    logic [15:0] vector;
  } nic_svc_t;

  // power state of the core as seen by the controller
  typedef enum logic [2:0] {
    PWR_RUN  = 3'b001,
    PWR_WAIT = 3'b010,
    PWR_HALT = 3'b100
  } nic_pwr_t;

endpackage : nic_pkg

// File: hw/nic_top.sv
// Functional notes
// - non-maskable sources ignore priority, enter level 3
// - reset and trap wake from halt
// - trap handled like top-level, preemptable by it
// - reset highest priority, runs at level 3
// - maskable served if enabled and higher
// - top-level request on selected pin edge
// - software selects each external line sensitivity
// - edge requests latched, cleared on service entry
// - selected pins of a group are NANDed
// - peripheral request needs flag and enable
// - clear sequence drops the request latch
// - all wake wait; only capable wake halt
// - halt exit serves capable winner first
// - hardware priority follows vector address order
// - level codes 10,01,00,11; 11 masks maskables
// - maskable entry loads vector pair into bits
// - instructions load or restore priority bits
// - priority registers reset FFh, upper bits of the last one fixed
// - writing level 0 keeps the old pair
// - top-level pair stored but not used
// - raised priority re-enters pending routine
// - time base wakes active-halt only
// - pick highest software, then hardware priority
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
module nic_top (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // register port
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [7:0]           reg_rdata_o,
  // pins (asynchronous)
  input  wire logic                 top_level_irq_i,
  input  wire logic [14:0]          ext_pins_i,
  // peripherals, indexed by vector number
  input  wire logic [13:0]          periph_flag_i,
  input  wire logic [13:0]          periph_en_i,
  input  wire logic [13:0]          periph_clear_i,
  input  wire logic                 active_halt_sel_i,
  // core side
  input  wire nic_pkg::nic_core_ev_t core_ev_i,
  output nic_pkg::nic_svc_t          svc_o,
  output logic                      prio_high_bit_o,
  output logic                      prio_low_bit_o,
  output logic                      wake_o
);

  // software priority code to ordered level number
  function automatic logic [2:0] lvl_of(input logic [1:0] b);
    unique case (b)
      nic_pkg::LVL0_BITS: lvl_of = 3'h0;
      nic_pkg::LVL1_BITS: lvl_of = 3'h1;
      nic_pkg::LVL2_BITS: lvl_of = 3'h2;
      default:            lvl_of = 3'h3;
    endcase
  endfunction : lvl_of

  // register write merge that refuses the level-0 code per pair
  function automatic logic [7:0] prio_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v);
    prio_merge = new_v;
    for (int p = 0; p < 4; p++)
      if (new_v[2*p+:2] == nic_pkg::LVL0_BITS)
        prio_merge[2*p+:2] = old_v[2*p+:2];
  endfunction : prio_merge

  // software visible registers
  logic [7:0]  prio_reg [4];                 // vector_priority_regs
  logic [7:0]  ext_irq_control_reg;          // two bits per line
  logic [14:0] pin_sel;                      // group pin selection
  logic        tli_rise;                     // top-level edge choice
  logic [1:0]  cc_bits;                      // {prio_high, prio_low}
  // request state
  logic [13:0] pend;                         // per-vector pending
  logic        reset_pend;                   // reset routine not started
  logic        trap_pend;                    // trap awaiting entry
  nic_pkg::nic_pwr_t pwr;                    // run, wait or halt
  logic        active_halt;                  // halt variant chosen
  // pin synchronisers
  logic        tli_s1, tli_s2, tli_prev;
  logic [14:0] pin_s1, pin_s2;
  logic [3:0]  line_prev;
  logic [3:0]  line_lvl;                     // NANDed group levels
  // arbitration results
  logic [31:0] prio_flat;
  logic [2:0]  cur_lvl;
  logic [15:0] cand;                         // eligible sources
  logic [15:0] src_pend;
  logic [2:0]  src_lvl [16];
  logic        best_valid;
  logic [3:0]  best_idx;
  logic [2:0]  best_lvl;
  logic        boundary;
  logic        take_now;
  logic [1:0]  next_cc;

  assign prio_flat = {prio_reg[3], prio_reg[2], prio_reg[1], prio_reg[0]};
  assign cur_lvl   = lvl_of(cc_bits);

  // two-flop synchronisers for every pin; first stage read by second only
  always_ff @(posedge clk_i)
  begin
    tli_s1 <= top_level_irq_i;
    tli_s2 <= tli_s1;
    pin_s1 <= ext_pins_i;
    pin_s2 <= pin_s1;
  end

  // a group line is active when any selected pin is low
  always_comb
  begin
    for (int l = 0; l < nic_pkg::NLINE; l++)
      line_lvl[l] = |(~pin_s2 & pin_sel & nic_pkg::nic_line_pins(l));
  end

  // edge history for the top-level pin and the four lines
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tli_prev  <= 1'b0;
      line_prev <= 4'h0;
    end
    else
    begin
      tli_prev  <= tli_s2;
      line_prev <= line_lvl;
    end
  end

  // register writes; top-level pair is kept but arbitration skips it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int r = 0; r < 4; r++)
        prio_reg[r] <= nic_pkg::PRIO_RESET;
      ext_irq_control_reg <= nic_pkg::EXT_CTL_RESET;
      pin_sel  <= nic_pkg::PIN_SEL_RESET;
      tli_rise <= nic_pkg::TLI_RISE_RESET;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        nic_pkg::ADDR_PRIO0: prio_reg[0] <= prio_merge(prio_reg[0], reg_wdata_i);
        nic_pkg::ADDR_PRIO1: prio_reg[1] <= prio_merge(prio_reg[1], reg_wdata_i);
        nic_pkg::ADDR_PRIO2: prio_reg[2] <= prio_merge(prio_reg[2], reg_wdata_i);
        // upper nibble of the last register stays at ones
        nic_pkg::ADDR_PRIO3: prio_reg[3] <= nic_pkg::PRIO3_RO_MASK |
                                 prio_merge(prio_reg[3], reg_wdata_i);
        nic_pkg::ADDR_EXT_CTL: ext_irq_control_reg <= reg_wdata_i;
        nic_pkg::ADDR_PIN_SEL_LO: pin_sel[7:0] <= reg_wdata_i;
        nic_pkg::ADDR_PIN_SEL_HI: pin_sel[14:8] <= reg_wdata_i[6:0];
        nic_pkg::ADDR_MISC_CTL: tli_rise <= reg_wdata_i[nic_pkg::MISC_TLI_RISE];
        default: ;                                  // unmapped writes ignored
      endcase
    end
  end

  // read data, valid in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        nic_pkg::ADDR_PRIO0:      reg_rdata_o <= prio_reg[0];
        nic_pkg::ADDR_PRIO1:      reg_rdata_o <= prio_reg[1];
        nic_pkg::ADDR_PRIO2:      reg_rdata_o <= prio_reg[2];
        nic_pkg::ADDR_PRIO3:      reg_rdata_o <= prio_reg[3];
        nic_pkg::ADDR_EXT_CTL:    reg_rdata_o <= ext_irq_control_reg;
        nic_pkg::ADDR_PEND_LO:    reg_rdata_o <= pend[7:0];
        nic_pkg::ADDR_PEND_HI:    reg_rdata_o <= {2'h0, pend[13:8]};
        nic_pkg::ADDR_CORE_STAT:  reg_rdata_o <= {pwr, active_halt, trap_pend,
                                                  reset_pend, cc_bits};
        nic_pkg::ADDR_PIN_SEL_LO: reg_rdata_o <= pin_sel[7:0];
        nic_pkg::ADDR_PIN_SEL_HI: reg_rdata_o <= {1'b0, pin_sel[14:8]};
        nic_pkg::ADDR_MISC_CTL:   reg_rdata_o <= {7'h00, tli_rise};
        default:                  reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // per-source view: index 0 reset, 1 trap, n+2 vector n
  always_comb
  begin
    src_pend    = {pend, trap_pend, reset_pend};
    src_lvl[0]  = nic_pkg::LVL_NMI;
    src_lvl[1]  = nic_pkg::LVL_NMI;
    src_lvl[2]  = nic_pkg::LVL_NMI;
    for (int v = 1; v < nic_pkg::NVEC; v++)
      src_lvl[v+2] = lvl_of(prio_flat[2*v+:2]);
  end

  // eligibility: non-maskable always, maskable only above current level;
  // in halt only sources able to leave halt compete
  always_comb
  begin
    cand[1:0] = 2'b11;
    cand[2]   = 1'b1;
    // pairs are read live, so a raised pair re-enters its routine
    for (int v = 1; v < nic_pkg::NVEC; v++)
      cand[v+2] = (src_lvl[v+2] > cur_lvl);
    if (pwr == nic_pkg::PWR_HALT)
    begin
      // time base counts only in the active variant
      cand[15:2] = cand[15:2] & (nic_pkg::HALT_CAP |
                   (active_halt ? nic_pkg::MCC_MASK : 14'h0000));
    end
    cand = cand & src_pend;
  end

  // winner: highest level, ties to lowest index (highest address)
  always_comb
  begin
    best_valid = 1'b0;
    best_idx   = 4'h0;
    best_lvl   = 3'h0;
    for (int s = nic_pkg::NSRC - 1; s >= 0; s--)
      if (cand[s] && (!best_valid || src_lvl[s] >= best_lvl))
      begin
        best_valid = 1'b1;
        best_idx   = 4'(s);
        best_lvl   = src_lvl[s];
      end
  end

  // entry happens at an instruction boundary or from a low-power state;
  // a halt winner is always capable, others follow next boundary
  // reset and a just executed trap need no further instruction boundary,
  // so both are entered on the very next edge
  assign boundary = core_ev_i.instr_end || (pwr != nic_pkg::PWR_RUN) ||
                    reset_pend || trap_pend;
  assign take_now = boundary && best_valid;

  // power state tracking; any pending request leaves wait
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pwr         <= nic_pkg::PWR_RUN;
      active_halt <= 1'b0;
    end
    else if (take_now)
      pwr <= nic_pkg::PWR_RUN;
    else if (core_ev_i.halt_instr)
    begin
      pwr         <= nic_pkg::PWR_HALT;
      active_halt <= active_halt_sel_i;
    end
    else if (core_ev_i.wait_for_irq_instr)
      pwr <= nic_pkg::PWR_WAIT;
  end

  // wake indication: registered, raised while asleep with a winner
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      wake_o <= 1'b0;
    else
      wake_o <= (pwr != nic_pkg::PWR_RUN) && best_valid;
  end

  // non-maskable latches; a new trap beats its own clear
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reset_pend <= 1'b1;
      trap_pend  <= 1'b0;
    end
    else
    begin
      if (take_now && best_idx == 4'h0)
        reset_pend <= 1'b0;
      if (core_ev_i.trap_instr)
        trap_pend <= 1'b1;
      else if (take_now && best_idx == 4'h1)
        trap_pend <= 1'b0;
    end
  end

  // per-vector request latches
  generate
    for (genvar v = 0; v < nic_pkg::NVEC; v++)
    begin : g_req
      logic served;
      assign served = take_now && (best_idx == 4'(v + 2));
      if (v == 0)
      begin : g_tli
        // selected edge sets; entry clears, a new edge wins
        always_ff @(posedge clk_i)
        begin
          if (srst_i)
            pend[v] <= 1'b0;
          else if (tli_rise ? (tli_s2 && !tli_prev)
                            : (!tli_s2 && tli_prev))
            pend[v] <= 1'b1;
          else if (served)
            pend[v] <= 1'b0;
        end
      end
      else if (nic_pkg::EXT_MASK[v])
      begin : g_ext
        localparam int L = v - nic_pkg::EXT_VEC0;
        logic [1:0] sens;
        logic       edge_hit;
        assign sens = ext_irq_control_reg[2*L+:2];
        assign edge_hit =
          ((sens == nic_pkg::SENS_RISE || sens == nic_pkg::SENS_BOTH) &&
            line_lvl[L] && !line_prev[L]) ||
          ((sens == nic_pkg::SENS_FALL || sens == nic_pkg::SENS_BOTH) &&
            !line_lvl[L] && line_prev[L]);
        // level mode follows the line; edge modes latch
        always_ff @(posedge clk_i)
        begin
          if (srst_i)
            pend[v] <= 1'b0;
          else if (sens == nic_pkg::SENS_LEVEL)
            pend[v] <= line_lvl[L];
          else if (edge_hit)
            pend[v] <= 1'b1;
          else if (served)
            pend[v] <= 1'b0;
        end
      end
      else if (nic_pkg::PERIPH_MASK[v])
      begin : g_per
        // the clear sequence wins: a waiting request is dropped, but a
        // flag still standing re-arms the latch on the next edge
        always_ff @(posedge clk_i)
        begin
          if (srst_i)
            pend[v] <= 1'b0;
          else if (periph_clear_i[v])
            pend[v] <= 1'b0;
          else
            pend[v] <= periph_flag_i[v] && periph_en_i[v];
        end
      end
      else
      begin : g_none
        assign pend[v] = 1'b0;                    // unused vector slot
      end
    end
  endgenerate

  // priority bits: entry loads, instructions load or restore
  always_comb
  begin
    next_cc = cc_bits;
    if (take_now)
      next_cc = (best_lvl == nic_pkg::LVL_NMI) ? nic_pkg::LVL3_BITS
              : prio_flat[2*(best_idx - 4'h2)+:2];
    else if (core_ev_i.irq_enable_instr || core_ev_i.halt_instr ||
             core_ev_i.wait_for_irq_instr)
      next_cc = nic_pkg::LVL0_BITS;
    else if (core_ev_i.irq_disable_instr || core_ev_i.trap_instr)
      next_cc = nic_pkg::LVL3_BITS;
    else if (core_ev_i.irq_return_instr || core_ev_i.pop_cc)
      next_cc = core_ev_i.pop_bits;
  end

  // current priority register; reset routine runs at level 3
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cc_bits <= nic_pkg::LVL3_BITS;
    else
      cc_bits <= next_cc;
  end

  // service hand-over to the core, one-cycle pulse
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      svc_o <= '0;
    else
    begin
      svc_o.take  <= take_now;
      svc_o.stack <= take_now && (best_idx != 4'h0); // reset stacks nothing
      if (take_now)
        svc_o.vector <= (best_idx == 4'h0) ? nic_pkg::RESET_VEC
                      : (best_idx == 4'h1) ? nic_pkg::TRAP_VEC
                      : 16'(nic_pkg::VEC0_ADDR -
                            {11'h000, best_idx - 4'h2, 1'b0});
    end
  end

  assign prio_high_bit_o = cc_bits[1];
  assign prio_low_bit_o  = cc_bits[0];

  // the first hand-over after reset is the reset vector, level 3
  a_reset_first: assert property (@(posedge clk_i)
    $fell(srst_i) |-> ##1 (svc_o.take && !svc_o.stack &&
      svc_o.vector == nic_pkg::RESET_VEC))
    else $error("reset vector not served first");

  // trap is entered within two cycles and at level 3
  a_trap_entry: assert property (@(posedge clk_i) disable iff (srst_i)
    core_ev_i.trap_instr && !reset_pend && !pend[0] |->
      ##[1:2] (take_now && best_idx == 4'h1))
    else $error("trap not entered");

  // non-maskable entry always leaves both priority bits set
  a_nmi_level: assert property (@(posedge clk_i) disable iff (srst_i)
    take_now && best_lvl == nic_pkg::LVL_NMI |=> cc_bits == 2'h3)
    else $error("non-maskable entry not at level 3");

  // a maskable entry never happens at or below current level
  a_mask_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    take_now && best_idx > 4'h2 |-> best_lvl > cur_lvl)
    else $error("maskable served without higher level");

  // maskable entry copies the vector pair into the priority bits
  a_entry_load: assert property (@(posedge clk_i) disable iff (srst_i)
    take_now && best_idx > 4'h2 |=>
      cc_bits == $past(prio_flat[2*(best_idx - 4'h2)+:2]))
    else $error("priority bits not loaded from vector pair");

  // the last register keeps its upper nibble at ones
  a_prio3_fixed: assert property (@(posedge clk_i) disable iff (srst_i)
    prio_reg[3][7:4] == 4'hF)
    else $error("fixed bits of priority register changed");

  // a level-0 write leaves a pair unchanged
  a_lvl0_kept: assert property (@(posedge clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == nic_pkg::ADDR_PRIO1 &&
      reg_wdata_i[5:4] == nic_pkg::LVL0_BITS |=>
      prio_reg[1][5:4] == $past(prio_reg[1][5:4]))
    else $error("level 0 stored in priority register");

  // in full halt the time base and unable vectors never win
  a_halt_capable: assert property (@(posedge clk_i) disable iff (srst_i)
    take_now && pwr == nic_pkg::PWR_HALT && best_idx > 4'h1 |->
      (nic_pkg::HALT_CAP[best_idx - 4'h2] ||
       (active_halt && best_idx == 4'h3)))
    else $error("halt left by incapable source");

  // peripheral pending follows flag and enable one cycle later
  a_periph_req: assert property (@(posedge clk_i) disable iff (srst_i)
    !periph_clear_i[7] && !(periph_flag_i[7] && periph_en_i[7])
      |=> !pend[7])
    else $error("peripheral request without flag and enable");

  // an edge request survives until it is served
  a_edge_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    pend[0] && !(take_now && best_idx == 4'h2) |=> pend[0])
    else $error("top-level request lost before service");

endmodule : nic_top

// File: tb/nic_core_model.sv
`timescale 1ns/10ps
// core model: ends an instruction every gap_i+1 cycles and carries
// all instruction events requested since the last boundary, ORed, out on that boundary
module nic_core_model (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // requests from the bench
  input  wire nic_pkg::nic_core_ev_t cmd_i,
  input  wire logic [3:0]            gap_i,
  // events to the controller
  output nic_pkg::nic_core_ev_t      core_ev_o
);
  logic [3:0]            cnt;   // cycles since the last boundary
  nic_pkg::nic_core_ev_t pend;  // event held until a boundary
  // a large gap models a slow core, zero a core that ends every cycle
  always_ff @(posedge clk_i)
  begin
    core_ev_o <= '0;
    if (srst_i)
    begin
      cnt  <= 4'h0;
      pend <= '0;
    end
    else if (cnt >= gap_i)
    begin
      cnt                 <= 4'h0;
      pend                <= '0;
      core_ev_o           <= pend | cmd_i;
      core_ev_o.instr_end <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 4'h1;
      pend <= pend | cmd_i;
    end
  end
endmodule : nic_core_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  // bench-driven inputs
  logic                  clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  logic [7:0]            addr = 8'h00;
  logic [7:0]            wdata = 8'h00;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic                  top_level_irq = 1'b1;
  logic [14:0]           pins = 15'h7FFF;
  logic [13:0]           flag = 14'h0000;
  logic [13:0]           en = 14'h0000;
  logic [13:0]           clr = 14'h0000;
  logic                  ahalt = 1'b0;
  nic_pkg::nic_core_ev_t cmd = '0;
  // observed outputs
  nic_pkg::nic_core_ev_t ev;
  nic_pkg::nic_svc_t     svc;
  logic [7:0]            rdata;
  logic                  ph;
  logic                  pl;
  logic                  wake;
  int                    err_count = 0;
  int                    n_compared = 0;

  nic_core_model u_core (.clk_i(clk_i), .srst_i(srst_i), .cmd_i(cmd),
    .gap_i(4'h3), .core_ev_o(ev));
  nic_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .top_level_irq_i(top_level_irq), .ext_pins_i(pins),
    .periph_flag_i(flag), .periph_en_i(en), .periph_clear_i(clr),
    .active_halt_sel_i(ahalt), .core_ev_i(ev), .svc_o(svc),
    .prio_high_bit_o(ph), .prio_low_bit_o(pl), .wake_o(wake));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask : wr_reg
  // read data appear in the cycle after the strobe and hold until the next read
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk
  // bounded wait for a service pulse; bits change in that same cycle
  task take_chk(input logic [15:0] vec, input logic stk,
                input logic [1:0] bits);
    // step past any pulse still standing from an earlier take
    @(posedge clk_i);
    #1;
    for (int i = 0; i < 40 && svc.take !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk({15'h0, svc.take}, 16'h1);
    chk(svc.vector, vec);
    chk({15'h0, svc.stack}, {15'h0, stk});
    chk({14'h0, ph, pl}, {14'h0, bits});
  endtask : take_chk
  // no service and no wake may appear for n cycles
  task no_take(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      chk({14'h0, svc.take, wake}, 16'h0);
    end
  endtask : no_take
  task send(input nic_pkg::nic_core_ev_t e);
    @(posedge clk_i);
    cmd <= e;
    @(posedge clk_i);
    cmd <= '0;
  endtask : send
  // an instruction event and the priority bits it leaves behind
  task instr(input nic_pkg::nic_core_ev_t e, input logic [1:0] bits);
    send(e);
    repeat (8) @(posedge clk_i);
    #1;
    chk({14'h0, ph, pl}, {14'h0, bits});
  endtask : instr

  task t_reset();
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    take_chk(nic_pkg::RESET_VEC, 1'b0, 2'h3);
    for (int a = 36; a < 40; a++) rd_chk(a[7:0], 8'hFF);
    rd_chk(8'h30, 8'h00);
  endtask : t_reset
  task t_regs();
    wr_reg(nic_pkg::ADDR_PRIO1, 8'hCF);
    wr_reg(nic_pkg::ADDR_PRIO1, 8'h64);
    rd_chk(nic_pkg::ADDR_PRIO1, 8'h44);
    wr_reg(nic_pkg::ADDR_PRIO3, 8'h00);
    rd_chk(nic_pkg::ADDR_PRIO3, 8'hF0);
  endtask : t_regs
  // vector 7 at level 1, vector 6 at level 2, core still at level 3
  task t_mask();
    @(posedge clk_i);
    flag <= 14'h00C0;
    no_take(20);
    en <= 14'h0080;
    no_take(20);
    send('{irq_enable_instr: 1'b1, default: '0});
    take_chk(16'hFFEC, 1'b1, 2'h1);
    en <= 14'h00C0;
    take_chk(16'hFFEE, 1'b1, 2'h0);
    clr <= 14'h00C0;
    flag <= 14'h0000;
    en <= 14'h0000;
    @(posedge clk_i);
    clr <= 14'h0000;
  endtask : t_mask
  task t_nmi();
    send('{trap_instr: 1'b1, default: '0});
    take_chk(nic_pkg::TRAP_VEC, 1'b1, 2'h3);
    top_level_irq <= 1'b0;
    take_chk(nic_pkg::VEC0_ADDR, 1'b1, 2'h3);
    top_level_irq <= 1'b1;
  endtask : t_nmi
  task t_instr();
    instr('{irq_return_instr: 1'b1, pop_bits: 2'h1, default: '0}, 2'h1);
    instr('{irq_enable_instr: 1'b1, default: '0}, 2'h2);
    instr('{irq_disable_instr: 1'b1, default: '0}, 2'h3);
    instr('{pop_cc: 1'b1, pop_bits: 2'h0, default: '0}, 2'h0);
  endtask : t_instr
  // full halt: time base must not wake, a both-edge pin line must
  task t_halt();
    wr_reg(nic_pkg::ADDR_PIN_SEL_LO, 8'h01);
    wr_reg(nic_pkg::ADDR_EXT_CTL, 8'h03);
    instr('{halt_instr: 1'b1, default: '0}, 2'h2);
    flag <= 14'h0002;
    en <= 14'h0002;
    no_take(20);
    pins <= 15'h7FFE;
    take_chk(16'hFFF6, 1'b1, 2'h3);
    chk({15'h0, wake}, 16'h1);
    // wait mode: the still pending time base wakes and is served
    send('{wait_for_irq_instr: 1'b1, default: '0});
    take_chk(16'hFFF8, 1'b1, 2'h3);
    chk({15'h0, wake}, 16'h1);
  endtask : t_halt

  task test_done();
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // the sequence needs well under 2000 cycles
  initial
  begin
    #500000;
    err_count++;
    test_done();
  end
  initial
  begin
    t_reset();
    t_regs();
    t_mask();
    t_nmi();
    t_instr();
    t_halt();
    test_done();
  end
endmodule : testbench
